// [error_accum.sv]
// Error counter accumulation and latching for one framer
`default_nettype none
module error_accum
    import framer_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic accum_mode_select,
    input wire logic manual_count_latch,
    input wire logic interval_sel,
    input wire logic tick_short,
    input wire logic tick_long,
    input wire logic err_event,
    output logic [ERR_W-1:0] err_count,
    output logic latch_pulse
);
    accum_state_t state_q, state_d;
    logic [ERR_W-1:0] acc_q, acc_d;
    logic [ERR_W-1:0] cnt_q, cnt_d;
    logic timed_end;
    logic manual_prev_q, manual_prev_d;
    logic do_latch;

    always_comb
    begin
        manual_prev_d = manual_count_latch;
        timed_end = interval_sel ? tick_long : tick_short;
        state_d = state_q;
        case (state_q)
            ACC_IDLE:
            begin
                if (accum_mode_select && manual_count_latch && !manual_prev_q)
                begin
                    state_d = ACC_LATCH;
                end
            end
            ACC_LATCH:
            begin
                state_d = ACC_IDLE;
            end
            default:
            begin
                state_d = ACC_IDLE;
            end
        endcase
        do_latch = accum_mode_select ? (state_q == ACC_LATCH) : timed_end;
        acc_d = acc_q;
        cnt_d = cnt_q;
        if (do_latch)
        begin
            cnt_d = acc_q;
            acc_d = ERR_ZERO;
        end
        else if (err_event && acc_q != {ERR_W{1'b1}})
        begin
            acc_d = acc_q + ERR_W'(1);
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_q <= ACC_IDLE;
            acc_q <= ERR_ZERO;
            cnt_q <= ERR_ZERO;
            manual_prev_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            acc_q <= acc_d;
            cnt_q <= cnt_d;
            manual_prev_q <= manual_prev_d;
        end
    end

    assign err_count = cnt_q;
    assign latch_pulse = do_latch;
endmodule : error_accum
`default_nettype wire

// [framer_ctrl_crc_errcnt_monitor.sv]
// Common control registers for two framers: CRC6 select, monitors, error latching
`default_nettype none
module framer_ctrl_crc_errcnt_monitor
    import framer_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    // Parallel control port, already synchronous to clk
    input wire logic [ADDR_W-1:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [DATA_W-1:0] bus_wdata,
    output logic [DATA_W-1:0] bus_rdata,
    // Interval select bits held in each framer's control register 3
    input wire logic interval_sel_a,
    input wire logic interval_sel_b,
    input wire logic tick_short,
    input wire logic tick_long,
    input wire logic err_event_a,
    input wire logic err_event_b,
    output logic [ERR_W-1:0] err_count_a,
    output logic [ERR_W-1:0] err_count_b,
    output logic counts_settling,
    // Channel data from the framer datapaths
    input wire logic rx_chan_valid_a,
    input wire logic [CHAN_W-1:0] rx_chan_num_a,
    input wire logic [DATA_W-1:0] rx_chan_data_a,
    input wire logic rx_chan_valid_b,
    input wire logic [CHAN_W-1:0] rx_chan_num_b,
    input wire logic [DATA_W-1:0] rx_chan_data_b,
    input wire logic tx_chan_valid_b,
    input wire logic [CHAN_W-1:0] tx_chan_num_b,
    input wire logic [DATA_W-1:0] tx_chan_data_b,
    output logic [DATA_W-1:0] rx_channel_monitor_reg_a,
    output logic [DATA_W-1:0] rx_channel_monitor_reg_b,
    output logic [DATA_W-1:0] tx_channel_monitor_reg_b,
    // CRC6 variant selects to the framers
    output logic rx_alt_crc6_select_a,
    output logic rx_alt_crc6_select_b,
    output logic tx_alt_crc6_select_b
);
    logic [DATA_W-1:0] rx_ctrl_a_q, rx_ctrl_a_d;
    logic [DATA_W-1:0] tx_ctrl_b_q, tx_ctrl_b_d;
    logic [DATA_W-1:0] rx_ctrl_b_q, rx_ctrl_b_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic [DATA_W-1:0] rx_mon_a_q, rx_mon_a_d;
    logic [DATA_W-1:0] rx_mon_b_q, rx_mon_b_d;
    logic [DATA_W-1:0] tx_mon_b_q, tx_mon_b_d;
    logic [WAIT_W-1:0] wait_q, wait_d;
    logic latch_a;
    logic latch_b;

    function automatic logic [CHAN_W-1:0] chan_sel(input logic [DATA_W-1:0] ctrl);
        chan_sel = ctrl[CHAN_MSB:CHAN_LSB];
    endfunction : chan_sel

    // Picks the selected channel's byte as it passes
    function automatic logic [DATA_W-1:0] monitor_next(
        input logic [DATA_W-1:0] cur,
        input logic [DATA_W-1:0] ctrl,
        input logic valid,
        input logic [CHAN_W-1:0] num,
        input logic [DATA_W-1:0] data
    );
        monitor_next = (valid && num == chan_sel(ctrl)) ? data : cur;
    endfunction : monitor_next

    // Register writes
    always_comb
    begin
        rx_ctrl_a_d = rx_ctrl_a_q;
        tx_ctrl_b_d = tx_ctrl_b_q;
        rx_ctrl_b_d = rx_ctrl_b_q;
        if (bus_wr)
        begin
            case (bus_addr)
                FRAMER_A_RECEIVE_CONTROL_OFS:
                begin
                    rx_ctrl_a_d = bus_wdata;
                end
                FRAMER_B_TRANSMIT_CONTROL_OFS:
                begin
                    tx_ctrl_b_d = bus_wdata & TX_CTRL_WMASK;
                end
                FRAMER_B_RECEIVE_CONTROL_OFS:
                begin
                    rx_ctrl_b_d = bus_wdata;
                end
                default:
                begin
                    rx_ctrl_a_d = rx_ctrl_a_q;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rx_ctrl_a_q <= FRAMER_A_RECEIVE_CONTROL_RST;
            tx_ctrl_b_q <= FRAMER_B_TRANSMIT_CONTROL_RST;
            rx_ctrl_b_q <= FRAMER_B_RECEIVE_CONTROL_RST;
        end
        else
        begin
            rx_ctrl_a_q <= rx_ctrl_a_d;
            tx_ctrl_b_q <= tx_ctrl_b_d;
            rx_ctrl_b_q <= rx_ctrl_b_d;
        end
    end

    // Register reads, answered on the edge after the strobe
    always_comb
    begin
        rdata_d = rdata_q;
        if (bus_rd)
        begin
            case (bus_addr)
                FRAMER_A_RECEIVE_CONTROL_OFS:
                begin
                    rdata_d = rx_ctrl_a_q;
                end
                FRAMER_B_TRANSMIT_CONTROL_OFS:
                begin
                    rdata_d = tx_ctrl_b_q;
                end
                FRAMER_B_RECEIVE_CONTROL_OFS:
                begin
                    rdata_d = rx_ctrl_b_q;
                end
                default:
                begin
                    rdata_d = UNMAPPED_READ;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rdata_q <= UNMAPPED_READ;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    error_accum u_accum_a (
        .clk(clk),
        .sys_rst(sys_rst),
        .accum_mode_select(rx_ctrl_a_q[ACCUM_MODE_BIT]),
        .manual_count_latch(rx_ctrl_a_q[MANUAL_LATCH_BIT]),
        .interval_sel(interval_sel_a),
        .tick_short(tick_short),
        .tick_long(tick_long),
        .err_event(err_event_a),
        .err_count(err_count_a),
        .latch_pulse(latch_a)
    );

    error_accum u_accum_b (
        .clk(clk),
        .sys_rst(sys_rst),
        .accum_mode_select(rx_ctrl_b_q[ACCUM_MODE_BIT]),
        .manual_count_latch(rx_ctrl_b_q[MANUAL_LATCH_BIT]),
        .interval_sel(interval_sel_b),
        .tick_short(tick_short),
        .tick_long(tick_long),
        .err_event(err_event_b),
        .err_count(err_count_b),
        .latch_pulse(latch_b)
    );

    // Settle window after any latch; a hint only, counts are valid from the latch edge
    always_comb
    begin
        wait_d = wait_q;
        if (latch_a || latch_b)
        begin
            wait_d = WAIT_LOAD;
        end
        else if (wait_q != WAIT_ZERO)
        begin
            wait_d = wait_q - WAIT_ONE;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wait_q <= WAIT_ZERO;
        end
        else
        begin
            wait_q <= wait_d;
        end
    end

    // Channel monitors
    always_comb
    begin
        rx_mon_a_d = monitor_next(rx_mon_a_q, rx_ctrl_a_q, rx_chan_valid_a,
                                  rx_chan_num_a, rx_chan_data_a);
        rx_mon_b_d = monitor_next(rx_mon_b_q, rx_ctrl_b_q, rx_chan_valid_b,
                                  rx_chan_num_b, rx_chan_data_b);
        tx_mon_b_d = monitor_next(tx_mon_b_q, tx_ctrl_b_q, tx_chan_valid_b,
                                  tx_chan_num_b, tx_chan_data_b);
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rx_mon_a_q <= MON_RST;
            rx_mon_b_q <= MON_RST;
            tx_mon_b_q <= MON_RST;
        end
        else
        begin
            rx_mon_a_q <= rx_mon_a_d;
            rx_mon_b_q <= rx_mon_b_d;
            tx_mon_b_q <= tx_mon_b_d;
        end
    end

    assign bus_rdata = rdata_q;
    assign counts_settling = (wait_q != WAIT_ZERO);
    assign rx_channel_monitor_reg_a = rx_mon_a_q;
    assign rx_channel_monitor_reg_b = rx_mon_b_q;
    assign tx_channel_monitor_reg_b = tx_mon_b_q;
    assign rx_alt_crc6_select_a = rx_ctrl_a_q[ALT_CRC6_BIT];
    assign rx_alt_crc6_select_b = rx_ctrl_b_q[ALT_CRC6_BIT];
    assign tx_alt_crc6_select_b = tx_ctrl_b_q[ALT_CRC6_BIT];
endmodule : framer_ctrl_crc_errcnt_monitor
`default_nettype wire

// [framer_ctrl_crc_errcnt_monitor_tb_top.sv]
// Testbench for the framer common control registers
`default_nettype none
module framer_ctrl_crc_errcnt_monitor_tb_top
    import framer_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, sys_rst, bus_wr, bus_rd, tick_short, tick_long, counts_settling;
    logic [7:0] bus_addr, bus_wdata, bus_rdata;
    logic [1:0] isel, err_ev;
    logic [2:0] cval, crc;
    logic [4:0] cnum [3];
    logic [7:0] cdata [3];
    logic [7:0] mon [3];
    logic [15:0] errc [2];
    logic [7:0] ofs [3] = '{8'h1e, 8'hbe, 8'hb9};
    logic [31:0] seed = 32'h0a7a_c8ae;
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;
    host_model u_host (.clk(clk), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));
    framer_ctrl_crc_errcnt_monitor u_framer_ctrl_crc_errcnt_monitor (.clk(clk),
        .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .interval_sel_a(isel[0]),
        .interval_sel_b(isel[1]), .tick_short(tick_short), .tick_long(tick_long),
        .err_event_a(err_ev[0]), .err_event_b(err_ev[1]), .err_count_a(errc[0]),
        .err_count_b(errc[1]), .counts_settling(counts_settling),
        .rx_chan_valid_a(cval[0]), .rx_chan_num_a(cnum[0]), .rx_chan_data_a(cdata[0]),
        .rx_chan_valid_b(cval[1]), .rx_chan_num_b(cnum[1]), .rx_chan_data_b(cdata[1]),
        .tx_chan_valid_b(cval[2]), .tx_chan_num_b(cnum[2]), .tx_chan_data_b(cdata[2]),
        .rx_channel_monitor_reg_a(mon[0]), .rx_channel_monitor_reg_b(mon[1]),
        .tx_channel_monitor_reg_b(mon[2]), .rx_alt_crc6_select_a(crc[0]),
        .rx_alt_crc6_select_b(crc[1]), .tx_alt_crc6_select_b(crc[2]));
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [7:0] wr_expect(input int i, input logic [7:0] d);
        return (i == 2) ? (d & 8'h9f) : d;
    endfunction : wr_expect
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : print_verdict
    task automatic errs(input int f, input int n);
        repeat (n)
        begin
            @(negedge clk);
            err_ev[f] = 1'b1;
            @(negedge clk);
            err_ev[f] = 1'b0;
        end
    endtask : errs
    task automatic tick(input logic lng);
        @(negedge clk);
        tick_long = lng;
        tick_short = !lng;
        @(negedge clk);
        tick_long = 1'b0;
        tick_short = 1'b0;
    endtask : tick
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fail_count++;
            print_verdict();
        end
    end
    initial
    begin
        logic [7:0] d;
        logic [7:0] e;
        logic [15:0] hold;
        int n;
        {sys_rst, tick_short, tick_long, isel, err_ev, cval} = 10'h200;
        for (int i = 0; i < 3; i++) {cnum[i], cdata[i]} = 13'h0000;
        repeat (12) @(negedge clk);
        sys_rst = 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            u_host.rd(ofs[i], d);
            chk("reset value", d, 16'h0000);
        end
        e = 8'(rnd());
        if (e inside {8'h1e, 8'hbe, 8'hb9}) e = 8'h01;
        u_host.rd(e, d);
        chk("unmapped read", d, 16'h0000);
        $display("test reset done");
        for (int k = 0; k < 4; k++)
            for (int i = 0; i < 3; i++)
            begin
                d = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'(rnd());
                u_host.wr(ofs[i], d);
                u_host.rd(ofs[i], e);
                chk("ctrl readback", e, wr_expect(i, d));
                chk("crc select", crc[i], d[7]);
            end
        $display("test registers done");
        for (int i = 0; i < 3; i++)
        begin
            n = (i == 0) ? 31 : rnd() % 32;
            d = 8'(rnd());
            u_host.wr(ofs[i], n[7:0]);
            @(negedge clk);
            {cval[i], cnum[i], cdata[i]} = {1'b1, n[4:0], d};
            @(negedge clk);
            {cnum[i], cdata[i]} = {n[4:0] + 5'h01, ~d};
            @(negedge clk);
            cval[i] = 1'b0;
            chk("monitor byte", mon[i], d);
        end
        $display("test monitor done");
        for (int f = 0; f < 2; f++)
        begin
            isel[f] = 1'(rnd());
            u_host.wr(ofs[f], 8'h00);
            tick(1'b0);
            tick(1'b1);
            n = 1 + rnd() % 20;
            errs(f, n);
            tick(!isel[f]);
            chk("unselected tick", errc[f], 16'h0000);
            tick(isel[f]);
            chk("timed count", errc[f], n[15:0]);
            u_host.wr(ofs[f], 8'h40);
            u_host.wr(ofs[f], 8'h60);
            u_host.settle();
            hold = errc[f];
            n = 1 + rnd() % 20;
            errs(f, n);
            tick(1'b0);
            tick(1'b1);
            chk("ticks in manual", errc[f], hold);
            u_host.wr(ofs[f], 8'h40);
            u_host.wr(ofs[f], 8'h60);
            u_host.settle();
            chk("manual count", errc[f], n[15:0]);
            n = rnd() % 20;
            errs(f, n);
            u_host.wr(ofs[f], 8'h40);
            u_host.wr(ofs[f], 8'h60);
            u_host.settle();
            chk("count restart", errc[f], n[15:0]);
        end
        $display("test error counts done");
        print_verdict();
    end
endmodule : framer_ctrl_crc_errcnt_monitor_tb_top
bind framer_ctrl_crc_errcnt_monitor framer_ctrl_sva u_framer_ctrl_sva (.clk(clk),
    .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .interval_sel_a(interval_sel_a),
    .tick_short(tick_short), .tick_long(tick_long), .counts_settling(counts_settling),
    .rx_chan_valid_a(rx_chan_valid_a), .rx_chan_num_a(rx_chan_num_a),
    .rx_chan_data_a(rx_chan_data_a), .rx_channel_monitor_reg_a(rx_channel_monitor_reg_a),
    .rx_alt_crc6_select_a(rx_alt_crc6_select_a), .rx_alt_crc6_select_b(rx_alt_crc6_select_b),
    .tx_alt_crc6_select_b(tx_alt_crc6_select_b));
`default_nettype wire

// [framer_ctrl_pkg.sv]
// Constants shared by the framer common control register block
`default_nettype none
package framer_ctrl_pkg;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned CHAN_W = 5;
    localparam int unsigned ERR_W = 16;

    localparam logic [ADDR_W-1:0] FRAMER_A_RECEIVE_CONTROL_OFS = 8'h1e;
    localparam logic [ADDR_W-1:0] FRAMER_B_TRANSMIT_CONTROL_OFS = 8'hb9;
    localparam logic [ADDR_W-1:0] FRAMER_B_RECEIVE_CONTROL_OFS = 8'hbe;

    localparam logic [DATA_W-1:0] FRAMER_A_RECEIVE_CONTROL_RST = 8'h00;
    localparam logic [DATA_W-1:0] FRAMER_B_TRANSMIT_CONTROL_RST = 8'h00;
    localparam logic [DATA_W-1:0] FRAMER_B_RECEIVE_CONTROL_RST = 8'h00;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

    // Field positions; CRC6 and channel fields shared by receive and transmit control layouts
    localparam int unsigned ALT_CRC6_BIT = 7;
    localparam int unsigned ACCUM_MODE_BIT = 6;
    localparam int unsigned MANUAL_LATCH_BIT = 5;
    localparam int unsigned CHAN_LSB = 0;
    localparam int unsigned CHAN_MSB = 4;

    // Writable bits of the transmit control register; 6 and 5 are unassigned
    localparam logic [DATA_W-1:0] TX_CTRL_WMASK = 8'h9f;

    localparam logic [ERR_W-1:0] ERR_ZERO = 16'h0000;
    localparam logic [DATA_W-1:0] MON_RST = 8'h00;

    // Host wait after a manual latch, rounded up to whole cycles
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned MANUAL_WAIT_NS = 972;
    localparam int unsigned MANUAL_WAIT_CYC = (MANUAL_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WAIT_W = 5;
    localparam logic [WAIT_W-1:0] WAIT_LOAD = WAIT_W'(MANUAL_WAIT_CYC);
    localparam logic [WAIT_W-1:0] WAIT_ZERO = 5'h00;
    localparam logic [WAIT_W-1:0] WAIT_ONE = 5'h01;

    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_ARMED = 2'b01,
        ACC_LATCH = 2'b11
    } accum_state_t;
endpackage : framer_ctrl_pkg
`default_nettype wire

// [framer_ctrl_sva.sv]
// Assertion checker for the framer common control registers
`default_nettype none
module framer_ctrl_sva
    import framer_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [DATA_W-1:0] bus_wdata,
    input wire logic [DATA_W-1:0] bus_rdata,
    input wire logic interval_sel_a,
    input wire logic tick_short,
    input wire logic tick_long,
    input wire logic counts_settling,
    input wire logic rx_chan_valid_a,
    input wire logic [CHAN_W-1:0] rx_chan_num_a,
    input wire logic [DATA_W-1:0] rx_chan_data_a,
    input wire logic [DATA_W-1:0] rx_channel_monitor_reg_a,
    input wire logic rx_alt_crc6_select_a,
    input wire logic rx_alt_crc6_select_b,
    input wire logic tx_alt_crc6_select_b
);
    logic [DATA_W-1:0] ctrl_a_q;
    logic [DATA_W-1:0] ctrl_a_d;
    logic wr_a;
    logic mapped;
    assign wr_a = bus_wr && bus_addr == FRAMER_A_RECEIVE_CONTROL_OFS;
    assign mapped = bus_addr inside {FRAMER_A_RECEIVE_CONTROL_OFS,
        FRAMER_B_RECEIVE_CONTROL_OFS, FRAMER_B_TRANSMIT_CONTROL_OFS};
    always_comb ctrl_a_d = wr_a ? bus_wdata : ctrl_a_q;
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst) ctrl_a_q <= FRAMER_A_RECEIVE_CONTROL_RST;
        else ctrl_a_q <= ctrl_a_d;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence manual_arm_s;
        wr_a && bus_wdata[6:5] == 2'b11 && !ctrl_a_q[5];
    endsequence
    sequence timed_end_s;
        !ctrl_a_q[6] && !wr_a && (interval_sel_a ? tick_long : tick_short);
    endsequence
    unmapped_read_a: assert property (bus_rd && !mapped |=> bus_rdata == UNMAPPED_READ)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (!bus_rd |=> $stable(bus_rdata))
        else $error("read data moved without a read");
    crc_rx_a_a: assert property (wr_a |=> rx_alt_crc6_select_a == $past(bus_wdata[7]))
        else $error("rx crc select a wrong");
    crc_rx_b_a: assert property (bus_wr && bus_addr == FRAMER_B_RECEIVE_CONTROL_OFS
        |=> rx_alt_crc6_select_b == $past(bus_wdata[7])) else $error("rx crc select b wrong");
    crc_tx_b_a: assert property (bus_wr && bus_addr == FRAMER_B_TRANSMIT_CONTROL_OFS
        |=> tx_alt_crc6_select_b == $past(bus_wdata[7])) else $error("tx crc select b wrong");
    monitor_copy_a: assert property (rx_chan_valid_a && !wr_a
        && rx_chan_num_a == ctrl_a_q[4:0] |=> rx_channel_monitor_reg_a == $past(rx_chan_data_a))
        else $error("monitor byte not copied");
    manual_latch_a: assert property (manual_arm_s |-> ##[2:4] counts_settling)
        else $error("manual latch missing");
    timed_latch_a: assert property (timed_end_s |-> ##[1:3] counts_settling)
        else $error("timed latch missing");
endmodule : framer_ctrl_sva
`default_nettype wire

// [host_model.sv]
// Host processor model on the parallel control port
`default_nettype none
module host_model
    import framer_ctrl_pkg::*;
(
    input wire logic clk,
    output logic [ADDR_W-1:0] bus_addr,
    output logic bus_wr,
    output logic bus_rd,
    output logic [DATA_W-1:0] bus_wdata,
    input wire logic [DATA_W-1:0] bus_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        bus_addr = 8'h00;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_wdata = 8'h00;
    end
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(negedge clk);
        bus_addr = a;
        bus_wdata = (a == FRAMER_B_TRANSMIT_CONTROL_OFS) ? (d & TX_CTRL_WMASK) : d;
        bus_wr = 1'b1;
        @(negedge clk);
        bus_wr = 1'b0;
        // Released lines show garbage, not the last value
        bus_addr = ~bus_addr;
        bus_wdata = ~bus_wdata;
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(negedge clk);
        bus_addr = a;
        bus_rd = 1'b1;
        @(negedge clk);
        bus_rd = 1'b0;
        bus_addr = ~bus_addr;
        @(negedge clk);
        d = bus_rdata;
    endtask : rd
    task automatic settle();
        repeat (MANUAL_WAIT_CYC + 1) @(negedge clk);
    endtask : settle
endmodule : host_model
`default_nettype wire
